// >>> design/hps_pio_setup.v
// Functional notes
// - Decode state: find direction, mark last frame PIO
// - Direction clear, no error: go outbound load
// - Direction set, no error: return idle
// - Decode error: report to link, go idle
// - Illegal-transition notice from link: go idle
// - Outbound load: shadows, byte count, optional interrupt
// - Outbound load done: go idle unconditionally
// - Outbound wait holds until link reports done
// - Block byte count reached: go end state
// - Abort primitive in data wait: go end
// - Soft reset in outbound wait or inbound initial wait: request SYNC, idle
// - End state: load ending values, then idle
// - Inbound transfer errors passed to link
// - Inbound initial wait holds until data readable
// - Data readable: load initial values, go inbound wait
// - Inbound advance: load status, interrupt follows bit
// - All PIO data in one data frame
`timescale 1ns/1ps
`default_nettype none
`include "hps_consts.vh"
module hps_pio_setup (
    // Clock and reset
    input  wire                    sys_clk,
    input  wire                    rst,
    // Received setup frame from link layer
    input  wire                    setup_frame_valid,
    input  wire                    setup_dir,
    input  wire                    setup_irq,
    input  wire [`HPS_REG_W-1:0]   setup_init_value,
    input  wire [`HPS_REG_W-1:0]   setup_start_status,
    input  wire [`HPS_REG_W-1:0]   setup_end_value,
    input  wire [`HPS_CNT_W-1:0]   setup_byte_count,
    input  wire                    setup_error,
    // Link layer notices
    input  wire                    link_illegal_transition,
    input  wire                    link_abort_rcvd,
    input  wire                    link_xfer_done,
    input  wire                    link_rx_started,
    input  wire                    link_xfer_error,
    input  wire                    link_word_strobe,
    // Host application side
    input  wire                    host_out_data_ready,
    input  wire                    host_in_data_ready,
    input  wire                    soft_reset_bit,
    input  wire                    device_reset_cmd,
    input  wire [1:0]              shadow_rd_addr,
    // Outputs to link layer
    output reg                     link_status_report,
    output reg                     link_send_sync,
    output reg                     link_err_to_eof,
    // Outputs to host application
    output reg                     pio_irq,
    output reg                     irq_pending,
    output reg                     last_frame_pio,
    output reg                     data_request_flag,
    output reg                     busy_flag,
    output reg                     xfer_dir_in,
    output reg  [`HPS_CNT_W-1:0]   byte_count,
    output reg  [2:0]              fsm_state,
    output wire [`HPS_REG_W-1:0]   shadow_rd_data
);
    reg [2:0]              state;
    reg [2:0]              next_state;
    reg [`HPS_CNT_W-1:0]   xfer_count;
    reg                    dir_in;
    reg                    irq_bit;
    reg [`HPS_REG_W-1:0]   init_value;
    reg [`HPS_REG_W-1:0]   start_status;
    reg [`HPS_REG_W-1:0]   end_value;
    reg                    sh_wr_en;
    reg [1:0]              sh_wr_addr;
    reg [`HPS_REG_W-1:0]   sh_wr_data;
    reg                    init_pend;
    wire                   reset_req;
    wire                   count_hit;

    // Host asks for soft reset or device reset
    assign reset_req = soft_reset_bit | device_reset_cmd;

    // Byte count of the current data block reached
    assign count_hit = link_word_strobe && (xfer_count + 1'b1 == byte_count) && (byte_count != `HPS_CNT_RST);

    // Shadow register storage
    hps_shadow_mem u_shadow (
        .sys_clk (sys_clk),
        .wr_en   (sh_wr_en),
        .wr_addr (sh_wr_addr),
        .wr_data (sh_wr_data),
        .rd_addr (shadow_rd_addr),
        .rd_data (shadow_rd_data)
    );

    // Next state decision
    always @* begin
        next_state = state;
        case (state)
            // Idle: new frame, or a data phase opens
            `HPS_ST_IDLE: begin
                if (setup_frame_valid) begin
                    next_state = `HPS_ST_DECODE;
                end else if (host_out_data_ready && !dir_in && byte_count != `HPS_CNT_RST) begin
                    next_state = `HPS_ST_OUT_WAIT;
                end else if (dir_in && irq_bit && byte_count != `HPS_CNT_RST && link_rx_started) begin
                    next_state = `HPS_ST_IN_INIT;
                end
            end
            // Decode: branch on error and direction
            `HPS_ST_DECODE: begin
                if (link_illegal_transition) begin
                    next_state = `HPS_ST_IDLE;
                end else if (setup_error) begin
                    next_state = `HPS_ST_IDLE;
                end else if (!dir_in) begin
                    next_state = `HPS_ST_OUT_LOAD;
                end else begin
                    next_state = `HPS_ST_IDLE;
                end
            end
            // Outbound load: always back to idle
            `HPS_ST_OUT_LOAD: begin
                if (link_illegal_transition) begin
                    next_state = `HPS_ST_IDLE;
                end else begin
                    next_state = `HPS_ST_IDLE;
                end
            end
            // Outbound wait: reset, abort, count or done
            `HPS_ST_OUT_WAIT: begin
                if (link_illegal_transition) begin
                    next_state = `HPS_ST_IDLE;
                end else if (reset_req) begin
                    next_state = `HPS_ST_IDLE;
                end else if (link_abort_rcvd) begin
                    next_state = `HPS_ST_END;
                end else if (count_hit || link_xfer_done) begin
                    next_state = `HPS_ST_END;
                end
            end
            // Inbound initial wait: data readable
            `HPS_ST_IN_INIT: begin
                if (link_illegal_transition) begin
                    next_state = `HPS_ST_IDLE;
                end else if (reset_req) begin
                    next_state = `HPS_ST_IDLE;
                end else if (link_rx_started && host_in_data_ready) begin
                    next_state = `HPS_ST_IN_WAIT;
                end
            end
            // Inbound wait: abort, count or done
            `HPS_ST_IN_WAIT: begin
                if (link_illegal_transition) begin
                    next_state = `HPS_ST_IDLE;
                end else if (link_abort_rcvd) begin
                    next_state = `HPS_ST_END;
                end else if (count_hit || link_xfer_done) begin
                    next_state = `HPS_ST_END;
                end
            end
            // End: ending values, then idle
            `HPS_ST_END: begin
                next_state = `HPS_ST_IDLE;
            end
            default: begin
                next_state = `HPS_ST_IDLE;
            end
        endcase
    end

    // Shadow write selection per state
    always @* begin
        sh_wr_en   = 1'b0;
        sh_wr_addr = `HPS_SH_STATUS;
        sh_wr_data = `HPS_REG_RST;
        if (state == `HPS_ST_OUT_LOAD && !link_illegal_transition) begin
            sh_wr_en   = 1'b1;
            sh_wr_addr = `HPS_SH_INIT;
            sh_wr_data = init_value;
        end else if (state == `HPS_ST_IN_INIT && next_state == `HPS_ST_IN_WAIT) begin
            sh_wr_en   = 1'b1;
            sh_wr_addr = `HPS_SH_STATUS;
            sh_wr_data = start_status;
        end else if (state == `HPS_ST_IN_WAIT && init_pend) begin
            sh_wr_en   = 1'b1;
            sh_wr_addr = `HPS_SH_INIT;
            sh_wr_data = init_value;
        end else if (state == `HPS_ST_END) begin
            sh_wr_en   = 1'b1;
            sh_wr_addr = `HPS_SH_END;
            sh_wr_data = end_value;
        end
    end

    // Initial values owed to the shadow file after status
    always @(posedge sys_clk) begin
        if (rst) begin
            init_pend <= 1'b0;
        end else begin
            init_pend <= (state == `HPS_ST_IN_INIT) && (next_state == `HPS_ST_IN_WAIT);
        end
    end

    // State, captured frame fields and outputs
    always @(posedge sys_clk) begin
        if (rst) begin
            state              <= `HPS_ST_IDLE;
            fsm_state          <= `HPS_ST_IDLE;
            xfer_count         <= `HPS_CNT_RST;
            byte_count         <= `HPS_CNT_RST;
            dir_in             <= 1'b0;
            xfer_dir_in        <= 1'b0;
            irq_bit            <= 1'b0;
            init_value         <= `HPS_REG_RST;
            start_status       <= `HPS_REG_RST;
            end_value          <= `HPS_REG_RST;
            link_status_report <= 1'b0;
            link_send_sync     <= 1'b0;
            link_err_to_eof    <= 1'b0;
            pio_irq            <= 1'b0;
            irq_pending        <= 1'b0;
            last_frame_pio     <= 1'b0;
            data_request_flag  <= 1'b0;
            busy_flag          <= 1'b0;
        end else begin
            state              <= next_state;
            fsm_state          <= next_state;
            link_status_report <= 1'b0;
            link_send_sync     <= 1'b0;
            link_err_to_eof    <= 1'b0;
            // Latch frame fields as the frame arrives
            if (state == `HPS_ST_IDLE && setup_frame_valid) begin
                dir_in       <= setup_dir;
                xfer_dir_in  <= setup_dir;
                irq_bit      <= setup_irq;
                init_value   <= setup_init_value;
                start_status <= setup_start_status;
                end_value    <= setup_end_value;
                busy_flag    <= 1'b1;
            end
            // Decode: mark frame kind, report errors
            if (state == `HPS_ST_DECODE) begin
                last_frame_pio <= 1'b1;
                if (setup_error && !link_illegal_transition) begin
                    link_status_report <= 1'b1;
                end
                if (dir_in && !setup_error) begin
                    byte_count <= setup_byte_count;
                    xfer_count <= `HPS_CNT_RST;
                end
            end
            // Outbound load: count, request, pending flag
            if (state == `HPS_ST_OUT_LOAD && !link_illegal_transition) begin
                byte_count        <= setup_byte_count;
                xfer_count        <= `HPS_CNT_RST;
                data_request_flag <= 1'b1;
                busy_flag         <= 1'b0;
                if (irq_bit) begin
                    irq_pending <= 1'b1;
                end
            end
            // Count words in data wait states
            if ((state == `HPS_ST_OUT_WAIT || state == `HPS_ST_IN_WAIT) && link_word_strobe) begin
                xfer_count <= xfer_count + 1'b1;
            end
            // Soft or device reset asks for SYNC
            if ((state == `HPS_ST_OUT_WAIT || state == `HPS_ST_IN_INIT) && reset_req
                && !link_illegal_transition) begin
                link_send_sync <= 1'b1;
            end
            // Inbound advance: interrupt follows frame bit
            if (state == `HPS_ST_IN_INIT && next_state == `HPS_ST_IN_WAIT) begin
                irq_pending       <= irq_bit;
                pio_irq           <= irq_bit;
                data_request_flag <= 1'b1;
                busy_flag         <= 1'b0;
            end
            // Inbound errors ride the end of frame
            if (state == `HPS_ST_IN_WAIT && link_xfer_error) begin
                link_err_to_eof <= 1'b1;
            end
            // End: drop request and block count
            if (state == `HPS_ST_END) begin
                data_request_flag <= 1'b0;
                byte_count        <= `HPS_CNT_RST;
                busy_flag         <= 1'b0;
            end
            // Leaving for idle forgets the frame, except from outbound load or an error-free inbound decode
            if (next_state == `HPS_ST_IDLE && state != `HPS_ST_IDLE && state != `HPS_ST_OUT_LOAD
                && !(state == `HPS_ST_DECODE && dir_in && !setup_error)) begin
                dir_in      <= 1'b0;
                byte_count  <= `HPS_CNT_RST;
                busy_flag   <= 1'b0;
            end
            // Outbound interrupt follows frame bit
            if (state == `HPS_ST_OUT_LOAD) begin
                pio_irq <= irq_bit;
            end
        end
    end
endmodule // hps_pio_setup
`default_nettype wire

// >>> design/hps_consts.vh
`ifndef HPS_CONSTS_VH
`define HPS_CONSTS_VH
// State codes
`define HPS_ST_IDLE        3'h0
`define HPS_ST_DECODE      3'h1
`define HPS_ST_OUT_LOAD    3'h2
`define HPS_ST_OUT_WAIT    3'h3
`define HPS_ST_END         3'h4
`define HPS_ST_IN_INIT     3'h5
`define HPS_ST_IN_WAIT     3'h6
// Frame field positions (bit index in the setup word)
`define HPS_DIR_BIT        0
`define HPS_IRQ_BIT        1
// Shadow register index map
`define HPS_SH_STATUS      2'h0
`define HPS_SH_INIT        2'h1
`define HPS_SH_END         2'h2
`define HPS_SH_COUNT       2'h3
// Widths
`define HPS_REG_W          8
`define HPS_CNT_W          16
// Reset values
`define HPS_REG_RST        8'h00
`define HPS_CNT_RST        16'h0000
`endif

// >>> design/hps_shadow_mem.v
`timescale 1ns/1ps
`default_nettype none
`include "hps_consts.vh"
// Four-entry shadow register file, registered read data
module hps_shadow_mem (
    // Clock
    input  wire                    sys_clk,
    // Write port
    input  wire                    wr_en,
    input  wire [1:0]              wr_addr,
    input  wire [`HPS_REG_W-1:0]   wr_data,
    // Read port
    input  wire [1:0]              rd_addr,
    output reg  [`HPS_REG_W-1:0]   rd_data
);
    reg [`HPS_REG_W-1:0] mem [0:3];

    // Contents are left untouched by reset
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // hps_shadow_mem
`default_nettype wire

// >>> testbench/hps_sva.sv
`timescale 1ns/1ps
`default_nettype none
module hps_sva (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // Frame and link notices
    input wire logic       setup_frame_valid, setup_dir, setup_error,
    input wire logic       link_illegal_transition, link_abort_rcvd, link_xfer_done, link_word_strobe,
    // Host requests
    input wire logic       soft_reset_bit, device_reset_cmd,
    // Design outputs
    input wire logic       link_status_report, link_send_sync, last_frame_pio, pio_irq, irq_pending,
    input wire logic [2:0] fsm_state
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Idle frame enters decode, frame kind recorded
    take_frame_a: assert property (fsm_state == 3'h0 && setup_frame_valid |=>
        fsm_state == 3'h1 ##1 last_frame_pio) else $error("frame not decoded");
    // Decode branches on direction and error
    out_path_a: assert property (fsm_state == 3'h1 && !setup_error && !link_illegal_transition
        && !$past(setup_dir) |=> fsm_state == 3'h2) else $error("outbound load missed");
    in_path_a: assert property (fsm_state == 3'h1 && !setup_error && !link_illegal_transition
        && $past(setup_dir) |=> fsm_state == 3'h0) else $error("inbound decode not idle");
    dec_err_a: assert property (fsm_state == 3'h1 && setup_error && !link_illegal_transition |=>
        fsm_state == 3'h0 ##[0:1] link_status_report) else $error("decode error not reported");
    illegal_idle_a: assert property (fsm_state != 3'h0 && link_illegal_transition |=>
        fsm_state == 3'h0) else $error("illegal notice ignored");
    load_done_a: assert property (fsm_state == 3'h2 |=> fsm_state == 3'h0) else $error("load not left");
    // Outbound wait holds with no cause to leave
    out_hold_a: assert property (fsm_state == 3'h3 && !(link_xfer_done || link_abort_rcvd || link_word_strobe
        || link_illegal_transition || soft_reset_bit || device_reset_cmd) |=> $stable(fsm_state))
        else $error("outbound wait left early");
    wait_abort_a: assert property ((fsm_state == 3'h3 || fsm_state == 3'h6) && link_abort_rcvd
        && !link_illegal_transition && !soft_reset_bit && !device_reset_cmd |=> fsm_state == 3'h4)
        else $error("abort not ending");
    sync_req_a: assert property ((fsm_state == 3'h3 || fsm_state == 3'h5)
        && (soft_reset_bit || device_reset_cmd) && !link_illegal_transition
        |=> fsm_state == 3'h0 ##[0:1] link_send_sync) else $error("no sync");
    end_idle_a: assert property (fsm_state == 3'h4 |=> fsm_state == 3'h0) else $error("end not left");
    rst_idle_a: assert property (disable iff (1'b0) rst |=> fsm_state == 3'h0 && !irq_pending
        && !pio_irq) else $error("reset state wrong");
    // Main scenarios
    cover property (fsm_state == 3'h4);
    cover property (fsm_state == 3'h6);
    cover property (link_send_sync);
    cover property (link_status_report);
endmodule // hps_sva
bind hps_pio_setup hps_sva u_sva (.sys_clk, .rst, .setup_frame_valid, .setup_dir, .setup_error,
    .link_illegal_transition, .link_abort_rcvd, .link_xfer_done, .link_word_strobe, .soft_reset_bit,
    .device_reset_cmd, .link_status_report, .link_send_sync, .last_frame_pio, .pio_irq, .irq_pending, .fsm_state);
`default_nettype wire

// >>> testbench/hps_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module hps_link_model (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Burst request
    input  wire logic        go,
    input  wire logic        slow,
    input  wire logic [15:0] n_words,
    // Link notices
    output logic             link_word_strobe = 1'b0,
    output logic             link_xfer_done = 1'b0
);
    int   left = 0;
    logic ph = 1'b0;
    // Whole block in one burst, gaps when slow
    always @(posedge sys_clk) begin
        link_word_strobe <= 1'b0;
        link_xfer_done <= 1'b0;
        ph <= ~ph;
        if (rst) begin
            left <= 0;
        end else if (go) begin
            left <= n_words;
        end else if (left > 0 && (!slow || ph)) begin
            link_word_strobe <= 1'b1;
            link_xfer_done <= (left == 1);
            left <= left - 1;
        end
    end
endmodule // hps_link_model
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk = 0, rst = 1, setup_frame_valid = 0, setup_dir = 0, setup_irq = 0, setup_error = 0;
    logic link_illegal_transition = 0, link_abort_rcvd = 0, link_rx_started = 0, link_xfer_error = 0;
    logic host_out_data_ready = 0, host_in_data_ready = 0, soft_reset_bit = 0, device_reset_cmd = 0, go = 0, slow = 0;
    logic [7:0] setup_init_value = 0, setup_start_status = 0, setup_end_value = 0;
    logic [15:0] setup_byte_count = 0, seed = 16'hf857;
    logic [1:0] shadow_rd_addr = 0;
    logic [2:0] seen = 0;
    logic clr_seen = 0;
    wire link_word_strobe, link_xfer_done, link_status_report, link_send_sync, link_err_to_eof, pio_irq;
    wire irq_pending, last_frame_pio, data_request_flag, busy_flag, xfer_dir_in;
    wire [15:0] byte_count;
    wire [2:0] fsm_state;
    wire [7:0] shadow_rd_data;
    int fail_count = 0, comparisons = 0;
    hps_pio_setup uut (.sys_clk, .rst, .setup_frame_valid, .setup_dir, .setup_irq, .setup_init_value,
        .setup_start_status, .setup_end_value, .setup_byte_count, .setup_error, .link_illegal_transition,
        .link_abort_rcvd, .link_xfer_done, .link_rx_started, .link_xfer_error, .link_word_strobe,
        .host_out_data_ready, .host_in_data_ready, .soft_reset_bit, .device_reset_cmd, .shadow_rd_addr,
        .link_status_report, .link_send_sync, .link_err_to_eof, .pio_irq, .irq_pending, .last_frame_pio,
        .data_request_flag, .busy_flag, .xfer_dir_in, .byte_count, .fsm_state, .shadow_rd_data);
    hps_link_model lm (.sys_clk, .rst, .go, .slow, .n_words(setup_byte_count), .link_word_strobe, .link_xfer_done);
    // Clock and sticky pulse capture
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
        seen <= clr_seen ? 3'b000 : (seen | {link_err_to_eof, link_send_sync, link_status_report});
    task automatic test_done;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Bounded wait for a state
    task automatic wst(input logic [2:0] s);
        for (int i = 0; i < 60 && fsm_state !== s; i++) tick();
        chk("state", s, fsm_state);
        if (fsm_state !== s) test_done();
    endtask
    task automatic rsh(input logic [1:0] a, input logic [7:0] e);
        shadow_rd_addr = a;
        tick(2);
        chk("shadow", e, shadow_rd_data);
    endtask
    // Shift register for random frame fields
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Random frame from the shift register, sent from idle
    task automatic frame(input logic d, input logic q, input logic e);
        wst(3'h0);
        seed = lfsr(seed);
        {setup_start_status, setup_init_value} = seed;
        setup_end_value = seed[7:0] ^ 8'h5a;
        setup_byte_count = {13'h0000, seed[2:0]} + 16'h0001;
        {setup_dir, setup_irq, setup_error, setup_frame_valid, clr_seen} = {d, q, e, 2'b11};
        tick();
        {setup_frame_valid, clr_seen} = 2'b00;
        chk("decode", 3'h1, fsm_state);
        chk("dir", d, xfer_dir_in);
        tick();
        chk("last_pio", 1, last_frame_pio);
        setup_error = 0;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        #1 rst = 0;
        chk("reset", 0, {irq_pending, pio_irq, last_frame_pio, data_request_flag, busy_flag, fsm_state});
        frame(0, 1, 0);
        chk("load", 3'h2, fsm_state);
        tick();
        chk("idle", 0, fsm_state);
        chk("pend", 1, irq_pending);
        chk("count", setup_byte_count, byte_count);
        chk("drq_busy", 2'b10, {data_request_flag, busy_flag});
        rsh(1, setup_init_value);
        host_out_data_ready = 1;
        wst(3);
        {host_out_data_ready, go} = 2'b01;
        tick();
        go = 0;
        wst(4);
        rsh(2, setup_end_value);
        chk("end", 0, {fsm_state, data_request_flag});
        frame(0, 0, 0);
        host_out_data_ready = 1;
        wst(3);
        {host_out_data_ready, link_abort_rcvd} = 2'b01;
        tick();
        link_abort_rcvd = 0;
        chk("abort", 3'h4, fsm_state);
        frame(0, 0, 1);
        tick();
        chk("err", 3'b001, {fsm_state, seen[0]});
        frame(0, 0, 0);
        link_illegal_transition = 1;
        tick();
        link_illegal_transition = 0;
        chk("illegal", 0, fsm_state);
        for (int k = 0; k < 2; k++) begin
            frame(0, 0, 0);
            host_out_data_ready = 1;
            wst(3);
            {host_out_data_ready, soft_reset_bit, device_reset_cmd} = k ? 3'b001 : 3'b010;
            tick();
            {soft_reset_bit, device_reset_cmd} = 0;
            tick();
            chk("sync", 3'b001, {fsm_state, seen[1]});
        end
        frame(1, 1, 0);
        chk("in_idle", 0, fsm_state);
        link_rx_started = 1;
        wst(5);
        tick(3);
        chk("hold", 3'h5, fsm_state);
        host_in_data_ready = 1;
        wst(6);
        chk("irq", 1, pio_irq);
        rsh(0, setup_start_status);
        rsh(1, setup_init_value);
        // Far side flags an error inside a data-in transfer
        {slow, go, link_xfer_error, host_in_data_ready} = 4'b1110;
        tick();
        {go, link_xfer_error} = 0;
        wst(4);
        tick();
        chk("eof_err", 3'b001, {fsm_state, seen[2]});
        frame(1, 1, 0);
        wst(5);
        soft_reset_bit = 1;
        tick();
        soft_reset_bit = 0;
        tick();
        chk("in_sync", 3'b001, {fsm_state, seen[1]});
        test_done();
    end
endmodule // testbench
`default_nettype wire
